/* common/sba_consts.svh */
// Address, subaddress and reset constants for the subbank register access.
// Assumes inclusion by bare name from the package and the design module.
//
// Functional notes
// - Each serial instance has a pointer choosing the register behind its data.
// - Serial data locations 39h, 49h, 35h act on the register the pointer picks.
// - Serial subaddresses 00h-0Eh decode to the fifteen basic control registers.
// - Serial subaddresses 010h-01Bh decode to twelve extra channel-enable registers.
// - The DMA priority/enable control register is reached directly, not subbanked.
// - The DMA pointer selects which subbanked register the next data access reaches.
// - DMA data locations 56h and 57h both act on the pointer-selected register.
// - Each access through the autoincrementing DMA location adds one to the pointer.
// - Accesses through the plain DMA location leave the pointer unchanged.
// - DMA subaddresses 00h-1Dh hold five registers for each of six channels.
// - DMA subaddresses 1Eh and 1Fh hold the shared program-page registers.
// - DMA subaddresses 20h and 21h hold element index registers zero and one.
// - DMA subaddresses 22h-23h hold frame indexes, up to 3Dh the reload set.
// - The autoincrementing DMA location is 56h, the plain one 57h.
// - Serial pointers sit at 38h, 48h, 34h; the DMA pointer at 55h.
`ifndef SBA_CONSTS_SVH
`define SBA_CONSTS_SVH

// -----------------------------------------------------------------------
// Memory-mapped addresses
// -----------------------------------------------------------------------
`define SBA_ADDR_SPTR0 7'h38
`define SBA_ADDR_SDATA0 7'h39
`define SBA_ADDR_SPTR1 7'h48
`define SBA_ADDR_SDATA1 7'h49
`define SBA_ADDR_SPTR2 7'h34
`define SBA_ADDR_SDATA2 7'h35
`define SBA_ADDR_DPREC 7'h54
`define SBA_ADDR_DPTR 7'h55
`define SBA_ADDR_DINC 7'h56
`define SBA_ADDR_DPLAIN 7'h57

// -----------------------------------------------------------------------
// Subaddress ranges and reset values
// -----------------------------------------------------------------------
`define SBA_SER_BASIC_LAST 16'h000E
`define SBA_SER_EXT_FIRST 16'h0010
`define SBA_SER_EXT_LAST 16'h001B
`define SBA_SER_REGS 27
`define SBA_DMA_LAST 16'h003D
`define SBA_DMA_REGS 62
`define SBA_RST_VAL 16'h0000

`endif

/* common/sba_pkg.sv */
// Types shared by the subbank register access design.
// Assumes sba_consts.svh is on the include path.
package sba_pkg;
   `include "sba_consts.svh"

   // Word carried by every register and data location.
   typedef logic [15:0] sba_word_t;

   // Target decoded from the memory-mapped address.
   typedef enum logic [2:0] {
      SBA_T_NONE = 3'b000,
      SBA_T_SPTR = 3'b001,
      SBA_T_SDATA = 3'b010,
      SBA_T_DPREC = 3'b011,
      SBA_T_DPTR = 3'b100,
      SBA_T_DINC = 3'b101,
      SBA_T_DPLAIN = 3'b110
   } sba_target_e;
endpackage : sba_pkg

/* hdl/sba_subbank_regs.sv */
// Subbank access for three serial-port control banks and the DMA bank.
// Assumes processor reads and writes arrive synchronous to ref_clk.
`timescale 1ns/1ps
`include "sba_consts.svh"

module sba_subbank_regs (
   input wire logic ref_clk, // Processor clock, 100 MHz.
   input wire logic rst, // Asynchronous reset, active high.
   input wire logic ce, // Clock enable; state frozen while low.
   input wire logic acc_rd, // Read strobe, one cycle per access.
   input wire logic acc_wr, // Write strobe, one cycle per access.
   input wire logic [6:0] acc_addr, // Memory-mapped word address.
   input wire sba_pkg::sba_word_t acc_wdata, // Write data.
   output sba_pkg::sba_word_t rd_data_q, // Read data, one cycle after read.
   output logic rd_valid_q, // Read data valid pulse.
   output sba_pkg::sba_word_t dma_priority_enable_ctrl_q, // Direct DMA ctrl.
   output sba_pkg::sba_word_t dma_subbank_pointer_q // Current DMA pointer.
);
   import sba_pkg::*;

   // --------------------------------------------------------------------
   // Storage
   // --------------------------------------------------------------------
   sba_word_t ser_ptr_q [0:2];
   sba_word_t ser_mem_q [0:2][0:`SBA_SER_REGS-1];
   sba_word_t dma_mem_q [0:`SBA_DMA_REGS-1];
   sba_target_e tgt;
   logic [1:0] inst;

   // Maps a serial subaddress to {valid, slot}; the gap at 0Fh is unmapped.
   function automatic logic [5:0] ser_slot(input sba_word_t p);
      logic [5:0] r;
      r = 6'h00;
      if (p <= `SBA_SER_BASIC_LAST) begin
         r = {1'b1, p[4:0]};
      end else if (p >= `SBA_SER_EXT_FIRST && p <= `SBA_SER_EXT_LAST) begin
         r = {1'b1, 5'(p - 16'h0001)};
      end
      return r;
   endfunction : ser_slot

   // --------------------------------------------------------------------
   // Address decode
   // --------------------------------------------------------------------
   // Resolves the accessed address to a target and a serial instance.
   always_comb begin
      tgt = SBA_T_NONE;
      inst = 2'h0;
      if (acc_addr == `SBA_ADDR_SPTR0) begin
         tgt = SBA_T_SPTR;
      end else if (acc_addr == `SBA_ADDR_SPTR1) begin
         tgt = SBA_T_SPTR;
         inst = 2'h1;
      end else if (acc_addr == `SBA_ADDR_SPTR2) begin
         tgt = SBA_T_SPTR;
         inst = 2'h2;
      end else if (acc_addr == `SBA_ADDR_SDATA0) begin
         tgt = SBA_T_SDATA;
      end else if (acc_addr == `SBA_ADDR_SDATA1) begin
         tgt = SBA_T_SDATA;
         inst = 2'h1;
      end else if (acc_addr == `SBA_ADDR_SDATA2) begin
         tgt = SBA_T_SDATA;
         inst = 2'h2;
      end else if (acc_addr == `SBA_ADDR_DPREC) begin
         tgt = SBA_T_DPREC;
      end else if (acc_addr == `SBA_ADDR_DPTR) begin
         tgt = SBA_T_DPTR;
      end else if (acc_addr == `SBA_ADDR_DINC) begin
         tgt = SBA_T_DINC;
      end else if (acc_addr == `SBA_ADDR_DPLAIN) begin
         tgt = SBA_T_DPLAIN;
      end
   end

   // Subbank selection from the pointers; a write wins over a read.
   wire acc = acc_rd | acc_wr;
   wire do_wr = ce & acc_wr;
   wire sba_word_t cur_sptr = ser_ptr_q[inst];
   wire [5:0] slot = ser_slot(cur_sptr);
   wire ser_ok = slot[5];
   wire [4:0] ser_idx = slot[4:0];
   wire dma_ok = dma_subbank_pointer_q <= `SBA_DMA_LAST;
   wire [5:0] dma_idx = dma_subbank_pointer_q[5:0];
   wire dma_data = (tgt == SBA_T_DINC) || (tgt == SBA_T_DPLAIN);

   // Read data selection; unmapped targets and subaddresses read zero.
   wire sba_word_t ser_rd = ser_ok ? ser_mem_q[inst][ser_idx] : `SBA_RST_VAL;
   wire sba_word_t dma_rd = dma_ok ? dma_mem_q[dma_idx] : `SBA_RST_VAL;
   wire sba_word_t rd_mux =
      (tgt == SBA_T_SPTR) ? cur_sptr :
      (tgt == SBA_T_SDATA) ? ser_rd :
      (tgt == SBA_T_DPREC) ? dma_priority_enable_ctrl_q :
      (tgt == SBA_T_DPTR) ? dma_subbank_pointer_q :
      dma_data ? dma_rd : `SBA_RST_VAL;

   // Next DMA pointer: a pointer write loads, the autoincrement location
   // steps after any access, the plain location keeps it.
   wire sba_word_t dptr_d =
      (acc_wr && tgt == SBA_T_DPTR) ? acc_wdata :
      (acc && tgt == SBA_T_DINC) ? dma_subbank_pointer_q + 16'h0001 :
      dma_subbank_pointer_q;

   // --------------------------------------------------------------------
   // Registers
   // --------------------------------------------------------------------
   // Pointers and the direct DMA control register.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < 3; i++) begin
            ser_ptr_q[i] <= `SBA_RST_VAL;
         end
         dma_subbank_pointer_q <= `SBA_RST_VAL;
         dma_priority_enable_ctrl_q <= `SBA_RST_VAL;
      end else if (ce) begin
         dma_subbank_pointer_q <= dptr_d;
         if (acc_wr && tgt == SBA_T_SPTR) begin
            ser_ptr_q[inst] <= acc_wdata;
         end
         if (acc_wr && tgt == SBA_T_DPREC) begin
            dma_priority_enable_ctrl_q <= acc_wdata;
         end
      end
   end

   // Serial bank storage; writes to unmapped subaddresses are dropped.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < 3; i++) begin
            for (int j = 0; j < `SBA_SER_REGS; j++) begin
               ser_mem_q[i][j] <= `SBA_RST_VAL;
            end
         end
      end else if (do_wr && tgt == SBA_T_SDATA && ser_ok) begin
         ser_mem_q[inst][ser_idx] <= acc_wdata;
      end
   end

   // DMA bank storage behind both data locations.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         for (int k = 0; k < `SBA_DMA_REGS; k++) begin
            dma_mem_q[k] <= `SBA_RST_VAL;
         end
      end else if (do_wr && dma_data && dma_ok) begin
         dma_mem_q[dma_idx] <= acc_wdata;
      end
   end

   // Registered read answer, one cycle after the read strobe.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rd_data_q <= `SBA_RST_VAL;
         rd_valid_q <= 1'b0;
      end else if (ce) begin
         rd_valid_q <= acc_rd & ~acc_wr;
         if (acc_rd && !acc_wr) begin
            rd_data_q <= rd_mux;
         end
      end
   end

   // --------------------------------------------------------------------
   // Assertions
   // --------------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   a_ser_ptr_load: assert property (
      do_wr && tgt == SBA_T_SPTR |=> ser_ptr_q[$past(inst)] == $past(acc_wdata))
      else $error("serial pointer not loaded");
   a_ser_round_trip: assert property (
      (do_wr && tgt == SBA_T_SDATA && ser_ok && inst == 2'h1) ##1
      (ce && acc_rd && !acc_wr && tgt == SBA_T_SDATA && inst == 2'h1)
      |=> rd_data_q == $past(acc_wdata, 2))
      else $error("serial data not returned");
   a_ser_ext_decode: assert property (
      tgt == SBA_T_SDATA && cur_sptr == `SBA_SER_EXT_LAST
      |-> ser_ok && ser_idx == 5'd26)
      else $error("extended subaddress decode wrong");
   a_ser_unmapped: assert property (
      ce && acc_rd && !acc_wr && tgt == SBA_T_SDATA && !ser_ok
      |=> rd_data_q == 16'h0000)
      else $error("unmapped serial read not zero");
   a_prec_direct: assert property (
      do_wr && tgt == SBA_T_DPREC
      |=> dma_priority_enable_ctrl_q == $past(acc_wdata) &&
          $stable(dma_subbank_pointer_q))
      else $error("direct control write wrong");
   a_dma_ptr_load: assert property (
      do_wr && tgt == SBA_T_DPTR |=> dma_subbank_pointer_q == $past(acc_wdata))
      else $error("dma pointer not loaded");
   a_dma_round_trip: assert property (
      (do_wr && tgt == SBA_T_DPLAIN && dma_ok) ##1
      (ce && acc_rd && !acc_wr && tgt == SBA_T_DPLAIN)
      |=> rd_data_q == $past(acc_wdata, 2))
      else $error("dma data not returned");
   a_autoinc_step: assert property (
      ce && acc && tgt == SBA_T_DINC
      |=> dma_subbank_pointer_q == $past(dma_subbank_pointer_q) + 16'h0001)
      else $error("autoincrement missing");
   a_plain_hold: assert property (
      ce && acc && tgt == SBA_T_DPLAIN |=> $stable(dma_subbank_pointer_q))
      else $error("plain access moved pointer");
   a_dma_range_zero: assert property (
      ce && acc_rd && !acc_wr && tgt == SBA_T_DPLAIN && !dma_ok
      |=> rd_data_q == 16'h0000)
      else $error("dma read above range not zero");
   a_read_valid: assert property (
      ce && acc_rd && !acc_wr |=> rd_valid_q)
      else $error("read valid missing");
   // A cycle with no plain read, or with a write, gives no valid pulse.
   a_read_pulse: assert property (
      ce && !(acc_rd && !acc_wr) |=> !rd_valid_q)
      else $error("read valid without a read");

   c_autoinc_burst: cover property (
      ce && acc_wr && tgt == SBA_T_DINC ##1 ce && acc_wr && tgt == SBA_T_DINC);
   c_ser_ext_write: cover property (
      do_wr && tgt == SBA_T_SDATA && cur_sptr >= `SBA_SER_EXT_FIRST && ser_ok);
   c_ser_unmapped: cover property (
      ce && acc_rd && tgt == SBA_T_SDATA && !ser_ok);
   c_prec_write: cover property (do_wr && tgt == SBA_T_DPREC);
endmodule : sba_subbank_regs

/* tb/sba_cpu_model.sv */
// Processor core model that issues memory-mapped reads and writes.
// Assumes the register block samples its strobes on the rising clock edge.
`timescale 1ns/1ps

module sba_cpu_model (
   input wire logic ref_clk, // Processor clock.
   output logic ce, // Clock enable, set by the bench.
   output logic acc_rd, // Read strobe.
   output logic acc_wr, // Write strobe.
   output logic [6:0] acc_addr, // Word address.
   output sba_pkg::sba_word_t acc_wdata, // Write data.
   input wire sba_pkg::sba_word_t rd_data_q, // Read data.
   input wire logic rd_valid_q // Read data valid.
);
   import sba_pkg::*;

   // Idle bus at time zero.
   initial begin
      ce = 1'b1;
      acc_rd = 1'b0;
      acc_wr = 1'b0;
      acc_addr = 7'h00;
      acc_wdata = 16'h0000;
   end

   // Write one word; the strobe stays up so writes can run back to back.
   task automatic wr(input logic [6:0] a, input sba_word_t dv);
      @(negedge ref_clk);
      acc_rd = 1'b0;
      acc_wr = 1'b1;
      acc_addr = a;
      acc_wdata = dv;
      @(posedge ref_clk);
   endtask : wr

   // Read one word; the released bus shows the inverse of its last value.
   task automatic rd(input logic [6:0] a, output sba_word_t dv,
                     output logic v);
      @(negedge ref_clk);
      acc_wr = 1'b0;
      acc_rd = 1'b1;
      acc_addr = a;
      @(negedge ref_clk);
      acc_rd = 1'b0;
      acc_addr = ~a;
      acc_wdata = ~acc_wdata;
      dv = rd_data_q;
      v = rd_valid_q;
   endtask : rd

   // Return both strobes to idle at the next falling edge.
   task automatic idle();
      @(negedge ref_clk);
      acc_rd = 1'b0;
      acc_wr = 1'b0;
   endtask : idle

   // Change the clock enable at the next falling edge.
   task automatic set_ce(input logic en);
      @(negedge ref_clk);
      ce = en;
   endtask : set_ce

   // Read and write in one cycle; the block treats it as a write only.
   task automatic both(input logic [6:0] a, input sba_word_t dv,
                       output logic v);
      @(negedge ref_clk);
      acc_rd = 1'b1;
      acc_wr = 1'b1;
      acc_addr = a;
      acc_wdata = dv;
      @(negedge ref_clk);
      acc_rd = 1'b0;
      acc_wr = 1'b0;
      v = rd_valid_q;
   endtask : both
endmodule : sba_cpu_model

/* tb/tb_subbank_register_access.sv */
// Self-checking bench for the subbank register access block.
// Assumes sba_consts.svh is on the include path.
`timescale 1ns/1ps
`include "sba_consts.svh"

module tb_subbank_register_access;
   import sba_pkg::*;
   localparam logic [6:0] sp_addr[3] = '{`SBA_ADDR_SPTR0, `SBA_ADDR_SPTR1,
                                         `SBA_ADDR_SPTR2};
   localparam logic [6:0] sd_addr[3] = '{`SBA_ADDR_SDATA0, `SBA_ADDR_SDATA1,
                                         `SBA_ADDR_SDATA2};
   logic ref_clk;
   logic rst;
   logic ce, acc_rd, acc_wr, rd_valid_q;
   logic [6:0] acc_addr;
   sba_word_t acc_wdata, rd_data_q, ctrl_q, dptr_q, d, exp;
   logic v;
   int n_errors = 0;
   int n_tests = 0;

   // ----------------------------------------------------------------
   // Clock, design and processor model
   // ----------------------------------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   sba_subbank_regs uut (.ref_clk(ref_clk), .rst(rst), .ce(ce),
      .acc_rd(acc_rd), .acc_wr(acc_wr), .acc_addr(acc_addr),
      .acc_wdata(acc_wdata), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q),
      .dma_priority_enable_ctrl_q(ctrl_q), .dma_subbank_pointer_q(dptr_q));

   sba_cpu_model cpu (.ref_clk(ref_clk), .ce(ce), .acc_rd(acc_rd),
      .acc_wr(acc_wr), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
      .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q));

   // ----------------------------------------------------------------
   // Checking helpers
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [15:0] seen, exp_v);
      n_tests++;
      if (seen !== exp_v) begin
         n_errors++;
         $display("FAIL %s expected %h seen %h", nm, exp_v, seen);
      end
   endtask : chk

   // Read one location and compare data and the valid pulse.
   task automatic rdchk(input logic [6:0] a, input sba_word_t e);
      cpu.rd(a, d, v);
      chk("rd_valid_q", {15'h0000, v}, 16'h0001);
      chk("rd_data_q", d, e);
   endtask : rdchk

   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : summarize

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   // Fill every serial subaddress of all three banks, then read them back
   // so that one bank overwriting another shows up.
   task automatic t_serial();
      for (int i = 0; i < 3; i++)
         for (int s = 0; s < 29; s++) begin
            cpu.wr(sp_addr[i], 16'(s));
            cpu.wr(sd_addr[i], {4'hA, i[3:0], s[7:0]});
         end
      for (int i = 0; i < 3; i++)
         for (int s = 0; s < 29; s++) begin
            exp = (s == 15 || s > 27) ? 16'h0000 : {4'hA, i[3:0], s[7:0]};
            cpu.wr(sp_addr[i], 16'(s));
            rdchk(sd_addr[i], exp);
         end
      for (int i = 0; i < 3; i++)
         rdchk(sp_addr[i], 16'h001C);
      cpu.wr(sp_addr[1], 16'h0003);
      cpu.wr(sd_addr[1], 16'h4321);
      rdchk(sd_addr[1], 16'h4321);
      $display("test serial done");
   endtask : t_serial

   // Fill the DMA bank back to back through the stepping location.
   task automatic t_dma();
      cpu.wr(`SBA_ADDR_DPTR, 16'h0000);
      for (int s = 0; s < 62; s++)
         cpu.wr(`SBA_ADDR_DINC, 16'hD000 | 16'(s));
      cpu.idle();
      chk("pointer", dptr_q, 16'h003E);
      cpu.wr(`SBA_ADDR_DPTR, 16'h0000);
      rdchk(`SBA_ADDR_DPLAIN, 16'hD000);
      rdchk(`SBA_ADDR_DPLAIN, 16'hD000);
      chk("pointer", dptr_q, 16'h0000);
      for (int s = 0; s < 63; s++) begin
         exp = (s < 62) ? 16'hD000 | 16'(s) : 16'h0000;
         rdchk(`SBA_ADDR_DINC, exp);
      end
      chk("pointer", dptr_q, 16'h003F);
      rdchk(`SBA_ADDR_DPLAIN, 16'h0000);
      cpu.wr(`SBA_ADDR_DPTR, 16'h0005);
      cpu.wr(`SBA_ADDR_DPLAIN, 16'h1234);
      rdchk(`SBA_ADDR_DPLAIN, 16'h1234);
      rdchk(`SBA_ADDR_DINC, 16'h1234);
      chk("pointer", dptr_q, 16'h0006);
      $display("test dma done");
   endtask : t_dma

   // Direct control register, an unmapped address and a frozen clock enable.
   task automatic t_direct();
      cpu.wr(`SBA_ADDR_DPREC, 16'h5A5A);
      rdchk(`SBA_ADDR_DPREC, 16'h5A5A);
      chk("ctrl", ctrl_q, 16'h5A5A);
      chk("pointer", dptr_q, 16'h0006);
      rdchk(7'h36, 16'h0000);
      cpu.set_ce(1'b0);
      cpu.wr(`SBA_ADDR_DPTR, 16'h0022);
      cpu.rd(`SBA_ADDR_DPTR, d, v);
      chk("rd_valid_q", {15'h0000, v}, 16'h0000);
      chk("rd_data_q", d, 16'h0000);
      cpu.set_ce(1'b1);
      rdchk(`SBA_ADDR_DPTR, 16'h0006);
      cpu.both(`SBA_ADDR_DPREC, 16'hC3C3, v);
      chk("rd_valid_q", {15'h0000, v}, 16'h0000);
      rdchk(`SBA_ADDR_DPREC, 16'hC3C3);
      $display("test direct done");
   endtask : t_direct

   // ----------------------------------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      rst = 1'b1;
      repeat (10) @(posedge ref_clk);
      @(negedge ref_clk);
      rst = 1'b0;
      chk("pointer", dptr_q, `SBA_RST_VAL);
      rdchk(`SBA_ADDR_DPTR, `SBA_RST_VAL);
      t_serial();
      t_dma();
      t_direct();
      summarize();
   end

   // About 680 cycles are expected; stop a hang well beyond that.
   initial begin
      repeat (20000) @(posedge ref_clk);
      n_errors++;
      $display("Watchdog expired");
      summarize();
   end
endmodule : tb_subbank_register_access
